// >>> shared/fsl_pkg.sv
// constants shared by the fifo status and transmit length block
package fsl_pkg;
  // ==========================================================================
  // register map
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] TEST_MODE_CONTROL_ADDR = 5'h1B;
  localparam logic [ADDR_W-1:0] FIFO_FILL_STATUS_ADDR = 5'h1C;
  localparam logic [ADDR_W-1:0] TX_COUNT_HIGH_ADDR = 5'h1D;
  localparam logic [ADDR_W-1:0] TX_COUNT_LOW_ADDR = 5'h1E;
  localparam logic [ADDR_W-1:0] FIFO_DATA_ADDR = 5'h1F;
  // ==========================================================================
  // reset values
  localparam logic [7:0] TEST_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] TX_COUNT_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ==========================================================================
  // field positions
  localparam int unsigned CODER_FAST_CLOCK_BIT = 0;
  localparam int unsigned DECODER_TEST_BIT = 1;
  localparam int unsigned IO_TEST_BIT_LO = 2;
  localparam int unsigned IO_TEST_BIT_HI = 3;
  localparam int unsigned RF_AMPLITUDE_TEST_BIT = 7;
  localparam int unsigned STATUS_RESERVED_BIT = 7;
  localparam int unsigned STATUS_HIGH_BIT = 6;
  localparam int unsigned STATUS_LOW_BIT = 5;
  localparam int unsigned STATUS_OVERFLOW_BIT = 4;
  localparam int unsigned FILL_COUNT_BIT3 = 3;
  localparam int unsigned FILL_COUNT_BIT0 = 0;
  localparam logic [7:0] TEST_CLEAR_ON_STOP = 8'h0E;
  // ==========================================================================
  // fifo levels
  localparam int unsigned FIFO_BYTES = 12;
  localparam int unsigned FIFO_HIGH_LEVEL = 9;
  localparam int unsigned FIFO_LOW_LEVEL = 3;
  localparam int unsigned FIFO_WORDS = 16;
endpackage

// >>> hdl/fsl_fifo.sv
// byte fifo with valid and ready on both sides and a fill level
module fsl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned LVL_W = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LVL_W-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready = level_reg != LVL_W'(DEPTH);
  assign out_valid = level_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign level = level_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end
endmodule // fsl_fifo

// >>> hdl/fsl_test_ctrl.sv
// test mode control register with stop-condition clear
module fsl_test_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic chip_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic host_stop,
  output logic [7:0] ctrl_reg,
  output logic test_mode_reg
);
  logic [7:0] ctrl_next;

  // ==========================================================================
  // next value: write, then stop clears the test bits
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_en) begin
      ctrl_next = wr_data;
    end
    if (host_stop) begin
      ctrl_next = ctrl_next & ~fsl_pkg::TEST_CLEAR_ON_STOP;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= fsl_pkg::TEST_MODE_CONTROL_RST;
      test_mode_reg <= 1'b0;
    end else if (!chip_en) begin
      ctrl_reg <= fsl_pkg::TEST_MODE_CONTROL_RST;
      test_mode_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      // held until a stop or a host write clears the bits, or chip_en goes low
      test_mode_reg <= ctrl_next[fsl_pkg::DECODER_TEST_BIT]
        || ctrl_next[fsl_pkg::IO_TEST_BIT_LO]
        || ctrl_next[fsl_pkg::IO_TEST_BIT_HI];
    end
  end
endmodule // fsl_test_ctrl

// >>> hdl/fsl_top.sv
// fifo status, transmit length and test mode registers of the reader

module fsl_top #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned FIFO_DEPTH = fsl_pkg::FIFO_WORDS,
  parameter int unsigned FIFO_CAP = fsl_pkg::FIFO_BYTES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic chip_en,
  input wire logic [fsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic host_stop,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic tx_eof,
  input wire logic rx_byte_valid,
  input wire logic [DATA_W-1:0] rx_byte,
  output logic rx_byte_ready,
  input wire logic tx_pull,
  output logic [DATA_W-1:0] tx_byte,
  output logic tx_byte_valid,
  output logic [11:0] tx_count,
  output logic [3:0] tx_broken_info,
  output logic test_mode,
  output logic coder_fast_clock,
  output logic decoder_test,
  output logic [1:0] io_test,
  output logic rf_amplitude_test,
  output logic fifo_high,
  output logic fifo_low,
  output logic fifo_overflow
);
  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH + 1);

  // ==========================================================================
  // declarations
  logic [7:0] test_ctrl_reg;
  logic test_mode_reg;
  logic [7:0] tx_count_high_reg;
  logic [7:0] tx_count_low_reg;
  logic [DATA_W-1:0] reg_rdata_reg;
  logic reg_rvalid_reg;
  logic rx_byte_ready_reg;
  logic [DATA_W-1:0] tx_byte_reg;
  logic tx_byte_valid_reg;
  logic fifo_high_reg;
  logic fifo_low_reg;
  logic fifo_overflow_reg;
  logic [LVL_W-1:0] level;
  logic [LVL_W:0] level_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic room;
  logic sel_test;
  logic sel_status;
  logic sel_high;
  logic sel_low;
  logic sel_fifo;
  logic host_fifo_wr;
  logic host_fifo_rd;
  logic push_req;
  logic push;
  logic [DATA_W-1:0] push_data;
  logic pop_req;
  logic pop;
  logic [3:0] fill_field;
  logic [7:0] status_value;
  logic wr_test;
  logic wr_high;
  logic wr_low;
  logic rd_status;
  logic rd_fifo_data;
  logic overflow_event;
  logic tx_pop;
  logic [DATA_W-1:0] rdata_next;

  // ==========================================================================
  // address decode
  assign sel_test = reg_addr == fsl_pkg::TEST_MODE_CONTROL_ADDR;
  assign sel_status = reg_addr == fsl_pkg::FIFO_FILL_STATUS_ADDR;
  assign sel_high = reg_addr == fsl_pkg::TX_COUNT_HIGH_ADDR;
  assign sel_low = reg_addr == fsl_pkg::TX_COUNT_LOW_ADDR;
  assign sel_fifo = reg_addr == fsl_pkg::FIFO_DATA_ADDR;

  // ==========================================================================
  // host access events
  assign wr_test = reg_wr && sel_test;
  assign wr_high = reg_wr && sel_high;
  assign wr_low = reg_wr && sel_low;
  assign rd_status = reg_rd && sel_status;
  // a byte reaches the host only when the host owns the read side
  assign rd_fifo_data = host_fifo_rd && pop;
  // only host bytes count as overflow; receive bytes are held off instead
  assign overflow_event = host_fifo_wr && !(room && fifo_in_ready);
  assign tx_pop = tx_active && pop;

  // ==========================================================================
  // test mode control
  fsl_test_ctrl u_test_ctrl (
    .sys_clk(sys_clk),
    .reset(reset),
    .chip_en(chip_en),
    .wr_en(wr_test),
    .wr_data(reg_wdata[7:0]),
    .host_stop(host_stop),
    .ctrl_reg(test_ctrl_reg),
    .test_mode_reg(test_mode_reg)
  );

  assign test_mode = test_mode_reg;
  // encoders switch to the fast clock outside this block
  assign coder_fast_clock = test_ctrl_reg[fsl_pkg::CODER_FAST_CLOCK_BIT];
  assign decoder_test = test_ctrl_reg[fsl_pkg::DECODER_TEST_BIT];
  assign io_test = {test_ctrl_reg[fsl_pkg::IO_TEST_BIT_HI],
                    test_ctrl_reg[fsl_pkg::IO_TEST_BIT_LO]};
  assign rf_amplitude_test = test_ctrl_reg[fsl_pkg::RF_AMPLITUDE_TEST_BIT];

  // ==========================================================================
  // fifo source and sink selection
  // the direction inputs pick one owner per side, so the host cannot
  // corrupt a frame in flight
  // room caps the store at twelve of its sixteen words, so in_ready
  // never decides alone whether a byte is taken
  assign room = level < LVL_W'(FIFO_CAP);
  assign host_fifo_wr = reg_wr && sel_fifo && !rx_active;
  assign host_fifo_rd = reg_rd && sel_fifo && !tx_active;

  always_comb begin
    if (rx_active) begin
      push_req = rx_byte_valid && rx_byte_ready_reg && room;
      push_data = rx_byte;
    end else begin
      push_req = host_fifo_wr && room;
      push_data = reg_wdata;
    end
  end

  assign pop_req = tx_active ? tx_pull : host_fifo_rd;
  assign push = push_req && fifo_in_ready;
  assign pop = pop_req && fifo_out_valid;

  always_comb begin
    level_next = {1'b0, level};
    if (push && !pop) begin
      level_next = level_next + 1'b1;
    end else if (pop && !push) begin
      level_next = level_next - 1'b1;
    end
  end

  fsl_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(!chip_en),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop_req),
    .out_data(fifo_out_data),
    .level(level)
  );

  // ==========================================================================
  // receive back-pressure
  // ready is registered from the next level so a byte arriving on
  // the last free slot still lands; costs one cycle of slack
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_byte_ready_reg <= 1'b0;
    end else if (!chip_en) begin
      rx_byte_ready_reg <= 1'b0;
    end else begin
      rx_byte_ready_reg <= rx_active && (level_next < (LVL_W + 1)'(FIFO_CAP));
    end
  end

  assign rx_byte_ready = rx_byte_ready_reg;

  // ==========================================================================
  // transmit byte hand-out
  // registered, so the encoder sees its byte one cycle after the pull
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_byte_reg <= '0;
      tx_byte_valid_reg <= 1'b0;
    end else if (!chip_en) begin
      tx_byte_reg <= '0;
      tx_byte_valid_reg <= 1'b0;
    end else begin
      tx_byte_valid_reg <= tx_pop;
      if (tx_pop) begin
        tx_byte_reg <= fifo_out_data;
      end
    end
  end

  assign tx_byte = tx_byte_reg;
  assign tx_byte_valid = tx_byte_valid_reg;

  // ==========================================================================
  // level flags
  // taken from the next level so they agree with the fill field of the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fifo_high_reg <= 1'b0;
      fifo_low_reg <= 1'b0;
    end else if (!chip_en) begin
      fifo_high_reg <= 1'b0;
      fifo_low_reg <= 1'b0;
    end else begin
      fifo_high_reg <= rx_active
        && (level_next >= (LVL_W + 1)'(fsl_pkg::FIFO_HIGH_LEVEL));
      fifo_low_reg <= tx_active
        && (level_next <= (LVL_W + 1)'(fsl_pkg::FIFO_LOW_LEVEL));
    end
  end

  assign fifo_high = fifo_high_reg;
  assign fifo_low = fifo_low_reg;

  // ==========================================================================
  // overflow flag
  // sticky; a status read clears it, a new overflow in that cycle wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fifo_overflow_reg <= 1'b0;
    end else if (!chip_en) begin
      fifo_overflow_reg <= 1'b0;
    end else if (overflow_event) begin
      fifo_overflow_reg <= 1'b1;
    end else if (rd_status) begin
      fifo_overflow_reg <= 1'b0;
    end
  end

  assign fifo_overflow = fifo_overflow_reg;

  // ==========================================================================
  // transmit length registers
  // a host write in the same cycle as the frame end is kept
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_count_high_reg <= fsl_pkg::TX_COUNT_RST;
    end else if (!chip_en) begin
      tx_count_high_reg <= fsl_pkg::TX_COUNT_RST;
    end else if (wr_high) begin
      tx_count_high_reg <= reg_wdata[7:0];
    end else if (tx_eof) begin
      tx_count_high_reg <= fsl_pkg::TX_COUNT_RST;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_count_low_reg <= fsl_pkg::TX_COUNT_RST;
    end else if (!chip_en) begin
      tx_count_low_reg <= fsl_pkg::TX_COUNT_RST;
    end else if (wr_low) begin
      tx_count_low_reg <= reg_wdata[7:0];
    end else if (tx_eof) begin
      tx_count_low_reg <= fsl_pkg::TX_COUNT_RST;
    end
  end

  // high register carries bits 11..4, low nibble of count in low register
  assign tx_count = {tx_count_high_reg, tx_count_low_reg[7:4]};
  assign tx_broken_info = tx_count_low_reg[3:0];

  // ==========================================================================
  // status value
  // an empty fifo shows zero, the same as one byte; the level flags
  // cannot tell the two apart, only the fifo read does
  assign fill_field = (level == '0) ? 4'h0 : 4'(level - 1'b1);

  always_comb begin
    status_value = fsl_pkg::READ_ZERO;
    status_value[fsl_pkg::STATUS_RESERVED_BIT] = 1'b0;
    status_value[fsl_pkg::STATUS_HIGH_BIT] = fifo_high_reg;
    status_value[fsl_pkg::STATUS_LOW_BIT] = fifo_low_reg;
    status_value[fsl_pkg::STATUS_OVERFLOW_BIT] = fifo_overflow_reg;
    status_value[fsl_pkg::FILL_COUNT_BIT3:fsl_pkg::FILL_COUNT_BIT0] = fill_field;
  end

  // ==========================================================================
  // register read select
  // unmapped addresses, an empty fifo and an encoder-owned fifo read zero;
  // a fifo byte is shown only when this read really pops it
  always_comb begin
    rdata_next = fsl_pkg::READ_ZERO;
    if (sel_test) begin
      rdata_next = test_ctrl_reg;
    end else if (sel_status) begin
      rdata_next = status_value;
    end else if (sel_high) begin
      rdata_next = tx_count_high_reg;
    end else if (sel_low) begin
      rdata_next = tx_count_low_reg;
    end else if (rd_fifo_data) begin
      rdata_next = fifo_out_data;
    end
  end

  // ==========================================================================
  // register read port
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_reg <= '0;
      reg_rvalid_reg <= 1'b0;
    end else begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign reg_rvalid = reg_rvalid_reg;
endmodule // fsl_top

// >>> tb/fsl_stream_peer.sv
// stream peer model: encoder pulling and decoder feeding bytes
module fsl_stream_peer (
  input wire logic sys_clk,
  input wire logic pull_go,
  input wire logic feed_go,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic rx_byte_ready,
  output logic tx_pull,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic ph = 1'b0;
  logic [7:0] nxt = 8'h40;
  // ==========================================================================
  // behaviour
  // pulls kept a cycle apart so each one is a single-cycle pulse
  assign tx_pull = pull_go && !ph;
  assign rx_byte_valid = feed_go;
  // released data line shows the inverse of its last byte
  assign rx_byte = feed_go ? nxt : ~(nxt - 8'h01);
  always @(posedge sys_clk) begin
    ph <= pull_go && !ph;
    if (tx_byte_valid) got.push_back(tx_byte);
    if (feed_go && rx_byte_ready) nxt <= nxt + 8'h01;
  end
endmodule // fsl_stream_peer

// >>> tb/fsl_top_assertions.sv
// assertion checker for the fifo status and transmit length block
module fsl_top_assertions #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic chip_en,
  input wire logic [fsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic host_stop,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic tx_eof,
  input wire logic [11:0] tx_count,
  input wire logic [3:0] tx_broken_info,
  input wire logic test_mode,
  input wire logic coder_fast_clock,
  input wire logic decoder_test,
  input wire logic [1:0] io_test,
  input wire logic fifo_high,
  input wire logic fifo_low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire w1b = reg_wr && chip_en && reg_addr == fsl_pkg::TEST_MODE_CONTROL_ADDR;
  wire w1d = reg_wr && chip_en && reg_addr == fsl_pkg::TX_COUNT_HIGH_ADDR;
  // ==========================================================================
  // checks
  property p_enter; w1b && |reg_wdata[3:1] && !host_stop |=> test_mode; endproperty
  a_enter: assert property (p_enter) else $error("test mode not entered");
  property p_stop; host_stop |=> !test_mode && !decoder_test && io_test == 2'b00; endproperty
  a_stop: assert property (p_stop) else $error("stop left test bits");
  property p_off; !chip_en |=> !test_mode && !coder_fast_clock && tx_count == 12'h000; endproperty
  a_off: assert property (p_off) else $error("disable left state");
  property p_fast; w1b && reg_wdata[0] |=> coder_fast_clock; endproperty
  a_fast: assert property (p_fast) else $error("coder clock bit lost");
  property p_high; $rose(fifo_high) |-> $past(rx_active); endproperty
  a_high: assert property (p_high) else $error("high flag outside receive");
  property p_low; $rose(fifo_low) |-> $past(tx_active); endproperty
  a_low: assert property (p_low) else $error("low flag outside transmit");
  property p_len; w1d |=> tx_count[11:4] == $past(reg_wdata); endproperty
  a_len: assert property (p_len) else $error("count high byte wrong");
  property p_eof; tx_eof && chip_en && !reg_wr |=> tx_count == 12'h000 && tx_broken_info == 4'h0;
  endproperty
  a_eof: assert property (p_eof) else $error("length kept after eof");
  property p_rsv; reg_rd && reg_addr == fsl_pkg::FIFO_FILL_STATUS_ADDR |=> reg_rvalid && !reg_rdata[7];
  endproperty
  a_rsv: assert property (p_rsv) else $error("status bit 7 set");
endmodule // fsl_top_assertions

bind fsl_top fsl_top_assertions #(.DATA_W(DATA_W)) u_chk (.sys_clk, .reset, .chip_en, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .host_stop, .tx_active, .rx_active,
  .tx_eof, .tx_count, .tx_broken_info, .test_mode, .coder_fast_clock, .decoder_test, .io_test,
  .fifo_high, .fifo_low);

// >>> tb/tb.sv
// self-checking bench for the fifo status and transmit length block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [fsl_pkg::ADDR_W-1:0] TC = fsl_pkg::TEST_MODE_CONTROL_ADDR;
  localparam logic [fsl_pkg::ADDR_W-1:0] ST = fsl_pkg::FIFO_FILL_STATUS_ADDR;
  localparam logic [fsl_pkg::ADDR_W-1:0] LH = fsl_pkg::TX_COUNT_HIGH_ADDR;
  localparam logic [fsl_pkg::ADDR_W-1:0] LL = fsl_pkg::TX_COUNT_LOW_ADDR;
  localparam logic [fsl_pkg::ADDR_W-1:0] FD = fsl_pkg::FIFO_DATA_ADDR;
  logic sys_clk = 1'b0, reset = 1'b1, chip_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic host_stop = 1'b0, tx_active = 1'b0, rx_active = 1'b0, tx_eof = 1'b0;
  logic pull_go = 1'b0, feed_go = 1'b0;
  logic [fsl_pkg::ADDR_W-1:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic rx_byte_valid, rx_byte_ready, tx_pull, tx_byte_valid, reg_rvalid, test_mode;
  logic coder_fast_clock, decoder_test, rf_amplitude_test, fifo_high, fifo_low, fifo_overflow;
  logic [7:0] rx_byte, tx_byte, reg_rdata;
  logic [1:0] io_test;
  logic [11:0] tx_count;
  logic [3:0] tx_broken_info;
  logic [7:0] tv[4] = '{8'h02, 8'h04, 8'h08, 8'h8F};
  int fail_count = 0;
  int comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  fsl_top u_dut (.sys_clk, .reset, .chip_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .host_stop, .tx_active, .rx_active, .tx_eof, .rx_byte_valid,
    .rx_byte, .rx_byte_ready, .tx_pull, .tx_byte, .tx_byte_valid, .tx_count, .tx_broken_info,
    .test_mode, .coder_fast_clock, .decoder_test, .io_test, .rf_amplitude_test, .fifo_high,
    .fifo_low, .fifo_overflow);
  fsl_stream_peer u_peer (.sys_clk, .pull_go, .feed_go, .tx_byte_valid, .tx_byte,
    .rx_byte_ready, .tx_pull, .rx_byte_valid, .rx_byte);
  // ==========================================================================
  // tasks
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk($sformatf("reg %h", a), {4'h0, reg_rdata}, {4'h0, exp});
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    chip_en <= 1'b1;
    rdc(TC, 8'h00);
    rdc(LL, 8'h00);
    rdc(ST, 8'h00);
    rdc(5'h05, 8'h00);
    wr(TC, 8'h81);
    @(negedge sys_clk);
    chk("test_mode", test_mode, 1'b0);
    foreach (tv[i]) begin
      wr(TC, tv[i]);
      @(negedge sys_clk);
      chk("test_mode", test_mode, 1'b1);
      chk("test_bits", {io_test, decoder_test}, tv[i][3:1]);
      repeat (3) @(negedge sys_clk);
      chk("test_mode", test_mode, 1'b1);
      @(posedge sys_clk);
      host_stop <= 1'b1;
      @(posedge sys_clk);
      host_stop <= 1'b0;
      rdc(TC, tv[i] & 8'h81);
      chk("test_mode", test_mode, 1'b0);
      chk("test_bits", {io_test, decoder_test}, 3'h0);
    end
    chk("fast_clock", coder_fast_clock, 1'b1);
    chk("rf_level", rf_amplitude_test, 1'b1);
    wr(LH, 8'hA5);
    wr(LL, 8'h3C);
    @(negedge sys_clk);
    chk("tx_count", tx_count, 12'hA53);
    chk("broken", tx_broken_info, 4'hC);
    @(posedge sys_clk);
    tx_eof <= 1'b1;
    @(posedge sys_clk);
    tx_eof <= 1'b0;
    rdc(LH, 8'h00);
    rdc(LL, 8'h00);
    wr(LH, 8'h5A);
    // low enable for one edge clears registers and flushes the fifo
    @(posedge sys_clk);
    chip_en <= 1'b0;
    @(posedge sys_clk);
    chip_en <= 1'b1;
    rdc(LH, 8'h00);
    rdc(TC, 8'h00);
    for (int i = 0; i < 13; i++) wr(FD, 8'h10 + i[7:0]);
    @(negedge sys_clk);
    chk("overflow", fifo_overflow, 1'b1);
    rdc(ST, 8'h1B);
    chk("overflow", fifo_overflow, 1'b0);
    rdc(ST, 8'h0B);
    @(posedge sys_clk);
    tx_active <= 1'b1;
    pull_go <= 1'b1;
    repeat (18) @(posedge sys_clk);
    pull_go <= 1'b0;
    @(negedge sys_clk);
    chk("fifo_low", fifo_low, 1'b1);
    chk("pulled", 12'(u_peer.got.size()), 12'd9);
    foreach (u_peer.got[i]) chk("tx_byte", u_peer.got[i], 12'h010 + i[11:0]);
    rdc(FD, 8'h00);
    rdc(ST, 8'h22);
    @(posedge sys_clk);
    tx_active <= 1'b0;
    chip_en <= 1'b0;
    @(posedge sys_clk);
    chip_en <= 1'b1;
    rdc(ST, 8'h00);
    @(posedge sys_clk);
    rx_active <= 1'b1;
    feed_go <= 1'b1;
    repeat (20) @(posedge sys_clk);
    feed_go <= 1'b0;
    @(negedge sys_clk);
    chk("fifo_high", fifo_high, 1'b1);
    rdc(ST, 8'h4B);
    @(posedge sys_clk);
    rx_active <= 1'b0;
    for (int i = 0; i < 12; i++) rdc(FD, 8'h40 + i[7:0]);
    rdc(ST, 8'h00);
    tally_and_finish;
  end
  // hang guard, well beyond the roughly 180 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish;
  end
endmodule // tb
